/* core/sysint_unit.sv */
// Purpose: Reset sequencing, prescale counter, interrupt arbitration, wait/stop and status registers.
// Assumes: Inputs synchronous to i_clock; the CPU strobes instruction-end, trap, wait, stop and return.
// Notes:   The oscillator falling edge is modelled by the single rising-edge clock of this block.
//
// The register addresses and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module sysint_unit #(
	parameter int STAB_COUNT = sysint_pkg::STAB_CYCLES  // Stabilisation and stop recovery length.
) (
	input  wire logic                      i_clock,          // Oscillator clock, 50 MHz.
	input  wire logic                      i_resetn,         // Synchronous reset, active low.
	input  wire logic                      i_por_pulse,      // Power-on pulse, high.
	input  wire logic                      i_supply_low,     // Supply at or below trip level.
	input  wire logic                      i_wdog_rst,       // Watchdog timeout request.
	input  wire logic                      i_badop_rst,      // Illegal opcode request.
	input  wire logic                      i_badaddr_rst,    // Illegal fetch address request.
	input  wire logic                      i_monitor_rst,    // Forced monitor entry request.
	input  wire logic                      i_ext_rst_pin,    // External reset pin level.
	input  wire logic                      i_wdog_disable,   // Watchdog disable configuration bit.
	input  wire logic [7:0]                i_irq,            // Hardware interrupt requests, bit 7 highest.
	input  wire logic                      i_instr_end,      // Current instruction completes.
	input  wire logic                      i_trap_instr,     // Software trap executed.
	input  wire logic                      i_return_instr,   // Interrupt return executed.
	input  wire logic                      i_wait_instr,     // Wait instruction executed.
	input  wire logic                      i_stop_instr,     // Stop instruction executed.
	input  wire logic                      i_break,          // Break state active.
	input  wire logic                      i_mask_bit,       // CPU interrupt mask bit.
	input  wire logic                      i_prescale_clr,   // Watchdog service clears bits 12..4.
	input  wire logic [3:0]                i_avs_address,    // Avalon byte address.
	input  wire logic                      i_avs_read,       // Avalon read.
	input  wire logic                      i_avs_write,      // Avalon write.
	input  wire logic [31:0]               i_avs_writedata,  // Avalon write data.
	input  wire logic [3:0]                i_avs_byteenable, // Avalon byte enables.
	output logic [31:0]                    o_avs_readdata,   // Avalon read data.
	output logic                           o_avs_waitrequest,// Avalon wait request.
	output logic                           o_rst_pin_oe,     // Drive external reset pin low.
	output logic                           o_rst_pin_out,    // Reset pin output level, always 0.
	output logic                           o_internal_reset, // Internal reset to CPU and modules.
	output logic                           o_bus_clk_en,     // Internal bus clock enable.
	output logic                           o_cpu_clk_en,     // CPU clock enable.
	output logic                           o_periph_clk_en,  // Peripheral clock enable.
	output logic                           o_clkgen_en,      // Clock generator outputs enable.
	output logic                           o_wdog_tick,      // Watchdog clock pulse.
	output logic                           o_wdog_run,       // Watchdog allowed to run.
	output logic                           o_set_mask,       // Set mask bit pulse.
	output logic                           o_clear_mask,     // Clear mask bit pulse.
	output sysint_pkg::sysint_grant_t      o_grant,          // Interrupt grant and vector.
	output logic                           o_uv_request      // Qualified undervoltage request.
);
	localparam int STAB_W = $clog2(STAB_COUNT + sysint_pkg::RELEASE_CYCLES + 1);

	// ==========================================================
	// Helpers
	// Highest set bit index, used for arbitration.
	function automatic logic [2:0] sysint_top(input logic [7:0] v);
		logic [2:0] idx;
		idx = 3'h0;
		for (int k = 0; k < 8; k++)
		begin
			if (v[k])
				idx = 3'(k);
		end
		return idx;
	endfunction : sysint_top

	sysint_pkg::sysint_seq_t seq_r;
	logic [STAB_W-1:0]  seq_cnt_r;
	logic [3:0]         uv_cnt_r;
	logic [12:0]        pre_r;
	logic [6:0]         pin_cnt_r;
	logic [7:0]         cause_r;
	logic               bw_flag_r;
	logic               break_flag_clear_enable_r;
	logic [7:0]         int_en_r;
	logic [7:0]         latch_r;
	logic               latched_r;
	logic [2:0]         latched_idx_r;
	logic               wake_r;
	logic               stop_wake_r;
	logic               rd_pend_r;
	logic               int_src;
	logic               pin_low;
	logic [7:0]         pend;
	logic               cause_clr;
	logic               wr_acc;
	logic               clear_ok;
	logic [STAB_W-1:0]  oe_run_r;

	assign int_src   = uv_cnt_r == 4'(sysint_pkg::UV_TRIP_CYCLES) || i_wdog_rst || i_badop_rst
	                   || i_badaddr_rst || i_monitor_rst;
	assign pin_low   = !i_ext_rst_pin && !o_rst_pin_oe; // Our own drive must not read back as a pin reset.
	assign pend      = latch_r & int_en_r;
	assign clear_ok  = !i_break || break_flag_clear_enable_r;
	assign wr_acc    = i_avs_write && !o_avs_waitrequest; // Writes land on the answering edge only.
	assign cause_clr = rd_pend_r && i_avs_address == sysint_pkg::ADDR_RESET_CAUSE && clear_ok;

	// ==========================================================
	// Undervoltage qualifier: counts consecutive low-supply cycles.
	always_ff @(posedge i_clock)
	begin
		if (!i_resetn || !i_supply_low)
			uv_cnt_r <= 4'h0;
		else if (uv_cnt_r != 4'(sysint_pkg::UV_TRIP_CYCLES))
			uv_cnt_r <= uv_cnt_r + 4'h1;
	end
	always_ff @(posedge i_clock)
	begin
		if (!i_resetn)
			o_uv_request <= 1'b0;
		else
			o_uv_request <= uv_cnt_r == 4'(sysint_pkg::UV_TRIP_CYCLES);
	end

	// ==========================================================
	// Prescale counter. Internal resets and stop clear it; the pin does not.
	always_ff @(posedge i_clock)
	begin
		if (!i_resetn || i_por_pulse || int_src || seq_r == sysint_pkg::SEQ_STOP)
			pre_r <= 13'h0000;
		else if (i_prescale_clr)
			pre_r <= {9'h000, pre_r[3:0]};
		else
			pre_r <= pre_r + 13'h0001;
	end
	always_ff @(posedge i_clock)
	begin
		if (!i_resetn)
			o_wdog_tick <= 1'b0;
		else
			o_wdog_tick <= pre_r == 13'h1FFF;
	end

	// ==========================================================
	// Reset sequencer. All resets preempt interrupts without arbitration.
	always_ff @(posedge i_clock)
	begin
		if (!i_resetn || i_por_pulse || (uv_cnt_r == 4'(sysint_pkg::UV_TRIP_CYCLES)))
		begin
			seq_r     <= sysint_pkg::SEQ_STAB;
			seq_cnt_r <= '0;
		end
		else if (int_src)
		begin
			seq_r     <= sysint_pkg::SEQ_DRIVE;
			seq_cnt_r <= '0;
		end
		else if (pin_low && seq_r != sysint_pkg::SEQ_STAB)
		begin
			seq_r     <= sysint_pkg::SEQ_HOLD;
			seq_cnt_r <= '0;
		end
		else
		begin
			seq_cnt_r <= seq_cnt_r + 1'b1;
			case (seq_r)
				sysint_pkg::SEQ_STAB:
					if (seq_cnt_r == STAB_W'(STAB_COUNT + sysint_pkg::RELEASE_CYCLES - 1))
						seq_r <= sysint_pkg::SEQ_RUN;
				sysint_pkg::SEQ_DRIVE:
					if (seq_cnt_r == STAB_W'(sysint_pkg::PIN_DRIVE_CYCLES - 1))
					begin
						seq_r     <= sysint_pkg::SEQ_HOLD;
						seq_cnt_r <= '0;
					end
				sysint_pkg::SEQ_HOLD:
					if (seq_cnt_r == STAB_W'(sysint_pkg::HOLD_CYCLES - 1))
						seq_r <= sysint_pkg::SEQ_RUN;
				sysint_pkg::SEQ_RUN:
				begin
					seq_cnt_r <= '0;
					if (i_stop_instr)
						seq_r <= sysint_pkg::SEQ_STOP;
					else if (i_wait_instr)
						seq_r <= sysint_pkg::SEQ_WAIT;
				end
				sysint_pkg::SEQ_WAIT:
				begin
					seq_cnt_r <= '0;
					if (|pend || i_break)
						seq_r <= sysint_pkg::SEQ_RUN;
				end
				sysint_pkg::SEQ_STOP:
				begin
					if (stop_wake_r)
					begin
						if (seq_cnt_r == STAB_W'(STAB_COUNT - 1))
							seq_r <= sysint_pkg::SEQ_RUN;
					end
					else
						seq_cnt_r <= '0;
				end
				default:
					seq_r <= sysint_pkg::SEQ_RUN;
			endcase
		end
	end
	// Stop exit request is remembered while the recovery delay runs.
	always_ff @(posedge i_clock)
	begin
		if (!i_resetn || seq_r != sysint_pkg::SEQ_STOP)
			stop_wake_r <= 1'b0;
		else if (|pend || i_break)
			stop_wake_r <= 1'b1;
	end

	// ==========================================================
	// Pin drive and clock enables, registered from the sequencer.
	always_ff @(posedge i_clock)
	begin
		if (!i_resetn)
		begin
			o_rst_pin_oe     <= 1'b1;
			o_internal_reset <= 1'b1;
			o_bus_clk_en     <= 1'b0;
			o_cpu_clk_en     <= 1'b0;
			o_periph_clk_en  <= 1'b0;
			o_clkgen_en      <= 1'b1;
			o_wdog_run       <= 1'b0;
		end
		else
		begin
			o_rst_pin_oe     <= seq_r == sysint_pkg::SEQ_DRIVE
			                    || (seq_r == sysint_pkg::SEQ_STAB
			                        && seq_cnt_r < STAB_W'(STAB_COUNT));
			o_internal_reset <= seq_r == sysint_pkg::SEQ_STAB || seq_r == sysint_pkg::SEQ_DRIVE
			                    || seq_r == sysint_pkg::SEQ_HOLD;
			o_bus_clk_en     <= seq_r == sysint_pkg::SEQ_RUN || seq_r == sysint_pkg::SEQ_WAIT;
			o_cpu_clk_en     <= seq_r == sysint_pkg::SEQ_RUN;
			o_periph_clk_en  <= seq_r == sysint_pkg::SEQ_RUN || seq_r == sysint_pkg::SEQ_WAIT;
			o_clkgen_en      <= seq_r != sysint_pkg::SEQ_STOP;
			o_wdog_run       <= !i_wdog_disable && seq_r != sysint_pkg::SEQ_STOP;
		end
	end
	assign o_rst_pin_out = 1'b0;

	// ==========================================================
	// External pin qualification counter.
	always_ff @(posedge i_clock)
	begin
		if (!i_resetn || !pin_low)
			pin_cnt_r <= 7'h00;
		else if (pin_cnt_r != 7'(sysint_pkg::PIN_QUAL_CYCLES))
			pin_cnt_r <= pin_cnt_r + 7'h01;
	end

	// ==========================================================
	// Reset-cause flags. A new cause wins over a clearing read.
	always_ff @(posedge i_clock)
	begin
		if (!i_resetn || i_por_pulse)
			cause_r <= sysint_pkg::RESET_CAUSE_POR;
		else if (uv_cnt_r == 4'(sysint_pkg::UV_TRIP_CYCLES))
			cause_r <= 8'h01 << sysint_pkg::CAUSE_UV;
		else if (i_wdog_rst)
			cause_r <= 8'h01 << sysint_pkg::CAUSE_WDOG;
		else if (i_badop_rst)
			cause_r <= 8'h01 << sysint_pkg::CAUSE_BADOP;
		else if (i_badaddr_rst)
			cause_r <= 8'h01 << sysint_pkg::CAUSE_BADADDR;
		else if (i_monitor_rst)
			cause_r <= 8'h01 << sysint_pkg::CAUSE_MONITOR;
		else if (pin_cnt_r == 7'(sysint_pkg::PIN_QUAL_CYCLES - 1) && seq_r != sysint_pkg::SEQ_STAB)
			cause_r <= 8'h01 << sysint_pkg::CAUSE_PIN;
		else if (cause_clr)
			cause_r <= 8'h00;
	end

	// ==========================================================
	// Break-wait flag. Setting wins over a software clear.
	always_ff @(posedge i_clock)
	begin
		if (!i_resetn || o_internal_reset)
			bw_flag_r <= 1'b0;
		else if (seq_r == sysint_pkg::SEQ_WAIT && i_break)
			bw_flag_r <= 1'b1;
		else if (wr_acc && i_avs_address == sysint_pkg::ADDR_BREAK_WAIT && i_avs_byteenable[0]
		         && !i_avs_writedata[sysint_pkg::BIT_BREAK_WAIT_EXIT] && clear_ok)
			bw_flag_r <= 1'b0;
	end

	// ==========================================================
	// Writable control registers.
	always_ff @(posedge i_clock)
	begin
		if (!i_resetn)
		begin
			break_flag_clear_enable_r   <= 1'b0;
			int_en_r <= sysint_pkg::INT_ENABLE_RST;
		end
		else if (wr_acc && i_avs_byteenable[0])
		begin
			if (i_avs_address == sysint_pkg::ADDR_BREAK_FLAG)
				break_flag_clear_enable_r <= i_avs_writedata[sysint_pkg::BIT_BREAK_FLAG_CLEAR_ENABLE];
			if (i_avs_address == sysint_pkg::ADDR_INT_ENABLE)
				int_en_r <= i_avs_writedata[7:0];
		end
	end

	// ==========================================================
	// Avalon slave: one wait cycle, data returned on the release edge.
	always_ff @(posedge i_clock)
	begin
		if (!i_resetn)
		begin
			o_avs_waitrequest <= 1'b1;
			o_avs_readdata    <= 32'h00000000;
			rd_pend_r         <= 1'b0;
		end
		else
		begin
			o_avs_waitrequest <= !((i_avs_read || i_avs_write) && o_avs_waitrequest);
			rd_pend_r         <= i_avs_read && o_avs_waitrequest;
			if (i_avs_read && o_avs_waitrequest)
			begin
				case (i_avs_address)
					sysint_pkg::ADDR_BREAK_WAIT:  o_avs_readdata <= {30'h0, bw_flag_r, 1'b0};
					sysint_pkg::ADDR_RESET_CAUSE: o_avs_readdata <= {24'h0, cause_r};
					sysint_pkg::ADDR_BREAK_FLAG:  o_avs_readdata <= {24'h0, break_flag_clear_enable_r, 7'h00};
					sysint_pkg::ADDR_INT_ENABLE:  o_avs_readdata <= {24'h0, int_en_r};
					default:                      o_avs_readdata <= 32'h00000000;
				endcase
			end
		end
	end

	// ==========================================================
	// Interrupt latch and arbitration. A latched winner holds until served or the mask bit is set.
	always_ff @(posedge i_clock)
	begin
		if (!i_resetn || o_internal_reset)
			latch_r <= 8'h00;
		else
			latch_r <= (latch_r | i_irq) & ~(o_grant.take && !o_grant.trap ? 8'h01 << o_grant.vector : 8'h00);
	end
	always_ff @(posedge i_clock)
	begin
		if (!i_resetn || o_internal_reset || i_mask_bit || o_grant.take)
			latched_r <= 1'b0;
		else if (!latched_r && |pend)
		begin
			latched_r     <= 1'b1;
			latched_idx_r <= sysint_top(pend);
		end
	end
	// Wake from wait: stacking one cycle after the wake condition.
	always_ff @(posedge i_clock)
	begin
		if (!i_resetn)
			wake_r <= 1'b0;
		else
			wake_r <= seq_r == sysint_pkg::SEQ_WAIT && |pend;
	end
	// Grant at instruction end, after a return, on wake, or on a trap.
	// The stacked frame omits the high index register; the CPU stacks the rest.
	always_ff @(posedge i_clock)
	begin
		if (!i_resetn || o_internal_reset)
		begin
			o_grant      <= '0;
			o_set_mask   <= 1'b0;
			o_clear_mask <= 1'b0;
		end
		else
		begin
			o_clear_mask <= seq_r == sysint_pkg::SEQ_RUN && i_wait_instr;
			o_grant      <= '0;
			o_set_mask   <= 1'b0;
			if (i_trap_instr)
			begin
				o_grant.take <= 1'b1;
				o_grant.trap <= 1'b1;
				o_set_mask   <= 1'b1;
			end
			else if (latched_r && !i_mask_bit && (i_instr_end || i_return_instr || wake_r))
			begin
				o_grant.take   <= 1'b1;
				o_grant.vector <= latched_idx_r;
				o_set_mask     <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Checks.
	// Consecutive cycles the pin drive has stood, so drive length needs no long repetition.
	always_ff @(posedge i_clock)
	begin
		if (!i_resetn || !o_rst_pin_oe)
			oe_run_r <= '0;
		else
			oe_run_r <= oe_run_r + 1'b1;
	end
	a_uv_qualify: assert property (@(posedge i_clock) disable iff (!i_resetn)
		o_uv_request |-> $past(i_supply_low, 2)) else $error("Undervoltage request without low supply.");
	a_pin_drive_internal: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(int_src && seq_r == sysint_pkg::SEQ_RUN) |-> ##2 o_rst_pin_oe) else $error("Pin not driven.");
	a_drive_length: assert property (@(posedge i_clock) disable iff (!i_resetn)
		($fell(o_rst_pin_oe) && $past(seq_r, 2) == sysint_pkg::SEQ_DRIVE)
		|-> oe_run_r == STAB_W'(sysint_pkg::PIN_DRIVE_CYCLES)) else $error("Pin drive length wrong.");
	a_prescale_run: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(seq_r == sysint_pkg::SEQ_RUN && !int_src && !i_por_pulse && !i_prescale_clr && !i_stop_instr)
		|=> pre_r == $past(pre_r) + 13'h0001) else $error("Prescaler did not advance.");
	a_wdog_tick: assert property (@(posedge i_clock) disable iff (!i_resetn)
		o_wdog_tick |-> $past(pre_r) == 13'h1FFF) else $error("Watchdog tick off overflow.");
	a_trap_grant: assert property (@(posedge i_clock) disable iff (!i_resetn || o_internal_reset)
		i_trap_instr |=> o_grant.take && o_grant.trap) else $error("Trap not granted.");
	a_mask_blocks: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(o_grant.take && !o_grant.trap) |-> !$past(i_mask_bit)) else $error("Grant while masked.");
	a_wait_clocks: assert property (@(posedge i_clock) disable iff (!i_resetn)
		seq_r == sysint_pkg::SEQ_WAIT ##1 seq_r == sysint_pkg::SEQ_WAIT |-> !o_cpu_clk_en && o_periph_clk_en)
		else $error("Wait clock gating wrong.");
	a_stop_clocks: assert property (@(posedge i_clock) disable iff (!i_resetn)
		seq_r == sysint_pkg::SEQ_STOP |=> !o_clkgen_en && pre_r == 13'h0000) else $error("Stop not gated.");
	a_cause_clear: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(cause_clr && !int_src && !i_por_pulse && pin_cnt_r == 7'h00) |=> cause_r == 8'h00)
		else $error("Cause not cleared by read.");
	a_break_flag: assert property (@(posedge i_clock) disable iff (!i_resetn || o_internal_reset)
		(seq_r == sysint_pkg::SEQ_WAIT && i_break) |=> bw_flag_r) else $error("Break-wait flag not set.");
	c_uv_reset: cover property (@(posedge i_clock) disable iff (!i_resetn) o_uv_request);
	c_wait_wake: cover property (@(posedge i_clock) disable iff (!i_resetn) wake_r ##1 o_grant.take);
	c_stop_exit: cover property (@(posedge i_clock) disable iff (!i_resetn)
		seq_r == sysint_pkg::SEQ_STOP ##1 seq_r == sysint_pkg::SEQ_RUN);
	c_cause_read: cover property (@(posedge i_clock) disable iff (!i_resetn) cause_clr);
endmodule : sysint_unit
`default_nettype wire

/* inc/sysint_pkg.sv */
// Purpose: Shared constants and types for the system integration unit.
// Assumes: One 50 MHz clock stands in for the oscillator clock.
// Notes:   Register offsets are byte addresses on a 32-bit Avalon-MM slave.
package sysint_pkg;
	// ==========================================================
	// Register map
	localparam logic [3:0] ADDR_BREAK_WAIT   = 4'h0;
	localparam logic [3:0] ADDR_RESET_CAUSE  = 4'h4;
	localparam logic [3:0] ADDR_BREAK_FLAG   = 4'h8;
	localparam logic [3:0] ADDR_INT_ENABLE   = 4'hC;
	// Field positions.
	localparam int BIT_BREAK_WAIT_EXIT = 1;
	localparam int BIT_BREAK_FLAG_CLEAR_ENABLE            = 7;
	localparam int CAUSE_UV      = 1;
	localparam int CAUSE_MONITOR = 2;
	localparam int CAUSE_BADADDR = 3;
	localparam int CAUSE_BADOP   = 4;
	localparam int CAUSE_WDOG    = 5;
	localparam int CAUSE_PIN     = 6;
	localparam int CAUSE_POR     = 7;
	// Reset values.
	localparam logic [7:0] RESET_CAUSE_POR = 8'h80;
	localparam logic [7:0] INT_ENABLE_RST  = 8'h00;
	// ==========================================================
	// Timing constants, counted in oscillator cycles, then the prescaler width in bits and the interrupt count.
	localparam int UV_TRIP_CYCLES    = 9;
	localparam int STAB_CYCLES       = 4096;
	localparam int RELEASE_CYCLES    = 64;
	localparam int PIN_DRIVE_CYCLES  = 32;
	localparam int HOLD_CYCLES       = 32;
	localparam int PIN_QUAL_CYCLES   = 67;
	localparam int PRESCALE_WIDTH    = 13;
	localparam int NUM_IRQ           = 8;
	// ==========================================================
	// Sequencer states, Gray coded along the usual path.
	typedef enum logic [2:0] {
		SEQ_RUN   = 3'b000,
		SEQ_STAB  = 3'b001,
		SEQ_DRIVE = 3'b011,
		SEQ_HOLD  = 3'b010,
		SEQ_WAIT  = 3'b110,
		SEQ_STOP  = 3'b111
	} sysint_seq_t;
	// Interrupt grant handed to the CPU.
	typedef struct packed {
		logic       take;
		logic       trap;
		logic [2:0] vector;
	} sysint_grant_t;
endpackage : sysint_pkg

/* testbench/sysint_cpu_model.sv */
// Purpose: CPU mask bit and external reset wire facing the unit.
// Assumes: Mask pulses from the unit are one cycle wide.
// Notes:   The pin has a pull-up, so any party driving low wins.
`timescale 1ns/10ps
`default_nettype none
module sysint_cpu_model (
	input  wire logic i_clock,  // Clock.
	input  wire logic i_resetn, // Reset, active low.
	input  wire logic i_set,    // Set mask pulse.
	input  wire logic i_clr,    // Clear mask pulse.
	input  wire logic i_pin_oe, // Unit pulls pin low.
	input  wire logic i_ext_lo, // Board pulls pin low.
	output logic      o_mask,   // Mask bit.
	output logic      o_pin     // Pin level.
);
	// ==========
	// The core leaves reset masked, so no grant is free.
	always_ff @(posedge i_clock)
	begin
		if (!i_resetn || i_set)
			o_mask <= 1'b1;
		else if (i_clr)
			o_mask <= 1'b0;
	end
	// Wired low by either driver, else pulled up.
	assign o_pin = ~(i_pin_oe | i_ext_lo);
endmodule : sysint_cpu_model
`default_nettype wire

/* testbench/sysint_unit_test.sv */
// Purpose: Self-checking bench for the system integration unit.
// Assumes: STAB_COUNT is cut to 64 so reset sequences stay short.
// Notes:   Counts are taken at rising edges from registered outputs.
`timescale 1ns/10ps
`default_nettype none
module sysint_unit_test;
	logic        clk = 0, rstn = 0, por = 0, sup = 0, trap = 0, wt = 0, dis = 0, rd = 0, wr = 0;
	logic [3:0]  src = 0, adr = 0, be = 0;
	logic [7:0]  irq = 0;
	logic [31:0] wd = 0, q, rdat;
	logic        stp = 0, ext = 0, brk = 0;
	logic        wreq, oe, internal_reset_line, cpu, run, smask, cmask, uv, mask, pin, gen, bcl, per;
	sysint_pkg::sysint_grant_t g;
	int          failures = 0, num_checks = 0, cyc = 0, np, nh, nw, r;
	sysint_unit #(.STAB_COUNT(64)) dut_u (.i_clock(clk), .i_resetn(rstn), .i_por_pulse(por), .i_supply_low(sup),
		.i_wdog_rst(src[0]), .i_badop_rst(src[1]), .i_badaddr_rst(src[2]), .i_monitor_rst(src[3]),
		.i_ext_rst_pin(pin), .i_wdog_disable(dis), .i_irq(irq), .i_instr_end(1'b0), .i_trap_instr(trap),
		.i_return_instr(1'b0), .i_wait_instr(wt), .i_stop_instr(stp), .i_break(brk), .i_mask_bit(mask),
		.i_prescale_clr(1'b0), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
		.i_avs_byteenable(be), .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .o_rst_pin_oe(oe),
		.o_rst_pin_out(), .o_internal_reset(internal_reset_line), .o_bus_clk_en(bcl), .o_cpu_clk_en(cpu), .o_periph_clk_en(per),
		.o_clkgen_en(gen), .o_wdog_tick(), .o_wdog_run(run), .o_set_mask(smask), .o_clear_mask(cmask),
		.o_grant(g), .o_uv_request(uv));
	sysint_cpu_model cpu_u (.i_clock(clk), .i_resetn(rstn), .i_set(smask), .i_clr(cmask), .i_pin_oe(oe),
		.i_ext_lo(ext), .o_mask(mask), .o_pin(pin));
	// ==========
	// Clock and a hang guard that ends the run as a failure.
	always #10 clk = ~clk;
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			failures++;
			finish_test();
		end
	end
	task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e)
		begin
			failures++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask : check
	// Holds the request until waitrequest is seen low, then idles one edge.
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
		adr <= a;
		wd <= d;
		be <= b;
		rd <= !w;
		wr <= w;
		@(posedge clk);
		while (wreq !== 1'b0)
			@(posedge clk);
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge clk);
	endtask : bus
	// Measures wait to pin drive, pin drive length and the extra hold.
	task automatic span();
		{nw, np, nh} = 0;
		for (; oe !== 1'b1; nw++)
			@(posedge clk);
		sup <= 1'b0;
		for (; oe === 1'b1; np++)
			@(posedge clk);
		for (; internal_reset_line === 1'b1; nh++)
			@(posedge clk);
	endtask : span
	function automatic logic [2:0] top(input logic [7:0] v);
		top = 3'h0;
		for (int i = 0; i < 8; i++)
			if (v[i])
				top = i[2:0];
	endfunction : top
	task automatic finish_test();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : finish_test
	// ==========
	// Main sequence: resets, registers, wait wake and trap, then stop recovery and a pin reset.
	initial
	begin
		void'($urandom(32'h6063));
		dis = 1'($urandom);
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		span();
		por <= 1'b1;
		@(posedge clk);
		por <= 1'b0;
		span();
		check("por pin", 32'(np), 64);
		check("por hold", 32'(nh), 64);
		check("bus clock", bcl, 1);
		bus(0, sysint_pkg::ADDR_RESET_CAUSE, 0, 4'hF);
		check("cause por", q, 32'(sysint_pkg::RESET_CAUSE_POR));
		bus(0, sysint_pkg::ADDR_RESET_CAUSE, 0, 4'hF);
		check("cause cleared", q, 0);
		sup <= 1'b1;
		repeat (8) @(posedge clk);
		sup <= 1'b0;
		repeat (4) @(posedge clk);
		check("uv early", uv, 0);
		// Exactly nine low cycles trip the qualifier; the request shows one cycle later.
		sup <= 1'b1;
		repeat (sysint_pkg::UV_TRIP_CYCLES) @(posedge clk);
		sup <= 1'b0;
		repeat (2) @(posedge clk);
		check("uv delay", uv, 1);
		span();
		check("uv pin", 32'(np), 64);
		check("uv hold", 32'(nh), 64);
		bus(0, sysint_pkg::ADDR_RESET_CAUSE, 0, 4'hF);
		check("cause uv", q, 32'h2);
		for (int k = 0; k < 4; k++)
		begin
			src <= 4'h1 << k;
			@(posedge clk);
			src <= 4'h0;
			span();
			check("int pin", 32'(np), 32);
			check("int hold", 32'(nh), 32);
			bus(0, sysint_pkg::ADDR_RESET_CAUSE, 0, 4'hF);
			check("cause int", q, 32'h20 >> k);
		end
		bus(1, sysint_pkg::ADDR_INT_ENABLE, 32'hFF, 4'hE);
		bus(0, sysint_pkg::ADDR_INT_ENABLE, 0, 4'hF);
		check("enable refused", q, 0);
		bus(1, sysint_pkg::ADDR_INT_ENABLE, 32'hFF, 4'hF);
		bus(1, sysint_pkg::ADDR_BREAK_FLAG, 32'h80, 4'hF);
		bus(0, sysint_pkg::ADDR_BREAK_FLAG, 0, 4'hF);
		check("clear enable", q, 32'h80);
		bus(0, 4'h2, 0, 4'hF);
		check("unmapped", q, 0);
		// A break ends a wait and leaves its flag; a written zero clears it.
		wt <= 1'b1;
		@(posedge clk);
		wt <= 1'b0;
		repeat (2) @(posedge clk);
		check("mask cleared", mask, 0);
		brk <= 1'b1;
		@(posedge clk);
		brk <= 1'b0;
		bus(0, sysint_pkg::ADDR_BREAK_WAIT, 0, 4'hF);
		check("break wait set", q, 32'h2);
		bus(1, sysint_pkg::ADDR_BREAK_WAIT, 0, 4'hF);
		bus(0, sysint_pkg::ADDR_BREAK_WAIT, 0, 4'hF);
		check("break wait clear", q, 0);
		r = $urandom;
		wt <= 1'b1;
		@(posedge clk);
		wt <= 1'b0;
		repeat (2) @(posedge clk);
		check("cpu clock", cpu, 0);
		check("periph clock", per, 1);
		check("wdog run", run, !dis);
		irq <= r[7:0] | 8'h01;
		@(posedge clk);
		irq <= 8'h00;
		while (g.take !== 1'b1)
			@(posedge clk);
		check("vector", g.vector, top(r[7:0] | 8'h01));
		repeat (3) @(posedge clk);
		trap <= 1'b1;
		@(posedge clk);
		trap <= 1'b0;
		while (g.take !== 1'b1)
			@(posedge clk);
		check("trap", g.trap, 1);
		// Stop with a wake already pending; one stop cycle passes before the wake is seen.
		stp <= 1'b1;
		irq <= 8'h01;
		@(posedge clk);
		stp <= 1'b0;
		irq <= 8'h00;
		for (np = 0; gen === 1'b1; np++)
			@(posedge clk);
		for (np = 0; gen === 1'b0; np++)
			@(posedge clk);
		check("stop recovery", 32'(np), 65);
		// A board-driven pin reset held long enough to be recorded.
		ext <= 1'b1;
		repeat (sysint_pkg::PIN_QUAL_CYCLES) @(posedge clk);
		check("pin hold", internal_reset_line, 1);
		ext <= 1'b0;
		bus(0, sysint_pkg::ADDR_RESET_CAUSE, 0, 4'hF);
		check("cause pin", q, 32'h40);
		finish_test();
	end
endmodule : sysint_unit_test
`default_nettype wire
